// file: core/dcost_steering.sv
`timescale 1ns/1ps
`default_nettype none
module dcost_steering #(
  parameter int MS_CYC = dcost_pkg::MS_CYCLES
) (
  input  wire logic                                         clk_i,
  input  wire logic                                         sys_rst_i,
  input  wire dcost_pkg::dcost_mode_t [dcost_pkg::NCH-1:0]  mode_i,
  input  wire logic [dcost_pkg::NCH-1:0][dcost_pkg::SEL_W-1:0] repl_src_i,
  input  wire logic [dcost_pkg::FCW_W-1:0]                  sys_loop_i,
  input  wire logic [dcost_pkg::NCH-1:0][dcost_pkg::FCW_W-1:0] chan_loop_i,
  input  wire logic [dcost_pkg::NCH-1:0]                    refs_lost_i,
  input  wire logic [dcost_pkg::NCH-1:0][dcost_pkg::PCW_W-1:0] phase_err_i,
  input  wire logic [dcost_pkg::NCH-1:0][dcost_pkg::DEC_W-1:0] decim_i,
  input  wire logic [dcost_pkg::NCH-1:0]                    fcw_wr_i,
  input  wire logic [dcost_pkg::FCW_W-1:0]                  fcw_wdata_i,
  input  wire logic [dcost_pkg::NCH-1:0][dcost_pkg::FCW_W-1:0] step_i,
  input  wire logic                                         incdec_wr_i,
  input  wire logic [15:0]                                  incdec_i,
  input  wire logic                                         pin_step_en_i,
  input  wire logic [dcost_pkg::SEL_W-1:0]                  pin_step_ch_i,
  input  wire logic                                         pin_inc_i,
  input  wire logic                                         pin_dec_i,
  input  wire logic [dcost_pkg::NCH-1:0]                    pcw_wr_i,
  input  wire logic [dcost_pkg::PCW_W-1:0]                  pcw_wdata_i,
  input  wire logic [dcost_pkg::NCH-1:0]                    tmr_en_i,
  input  wire logic [dcost_pkg::NCH-1:0]                    tmr_hold_i,
  input  wire logic [dcost_pkg::TMR_W-1:0]                  tmr_ms_i,
  output wire logic [dcost_pkg::NCH-1:0][dcost_pkg::FCW_W-1:0] steer_o,
  output wire logic [dcost_pkg::NCH-1:0]                    steer_en_o,
  output wire logic [dcost_pkg::NCH-1:0]                    holdover_o,
  output wire logic [dcost_pkg::NCH-1:0][dcost_pkg::PCW_W-1:0] filter_err_o,
  output wire logic [dcost_pkg::NCH-1:0][dcost_pkg::PCW_W-1:0] phase_rd_o,
  output wire logic [dcost_pkg::NCH-1:0][dcost_pkg::FCW_W-1:0] fcw_o
);
  import dcost_pkg::*;

  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYC - 1);

  logic [FCW_W-1:0] steer_all [NCH];

  // pin steps come from outside the clock domain
  logic [1:0] inc_sy1_q, inc_sy1_d;
  logic [1:0] inc_sy2_q, inc_sy2_d;
  logic [1:0] inc_dly_q, inc_dly_d;
  logic       pin_inc_p;
  logic       pin_dec_p;

  always_comb begin
    inc_sy1_d = {pin_dec_i, pin_inc_i};
    inc_sy2_d = inc_sy1_q;
    inc_dly_d = inc_sy2_q;
    pin_inc_p = pin_step_en_i & inc_sy2_q[0] & ~inc_dly_q[0];
    pin_dec_p = pin_step_en_i & inc_sy2_q[1] & ~inc_dly_q[1];
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      inc_sy1_q <= 2'h0;
      inc_sy2_q <= 2'h0;
      inc_dly_q <= 2'h0;
    end else begin
      inc_sy1_q <= inc_sy1_d;
      inc_sy2_q <= inc_sy2_d;
      inc_dly_q <= inc_dly_d;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [FCW_W-1:0] fcw_q, fcw_d;
    logic [PCW_W-1:0] pcw_q, pcw_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic [PRE_W-1:0] pre_q, pre_d;
    logic [DEC_W-1:0] dcnt_q, dcnt_d;
    logic [PCW_W-1:0] prd_q, prd_d;
    logic [PCW_W-1:0] ferr_q, ferr_d;
    logic [FCW_W-1:0] steer_q, steer_d;
    logic             sten_q, sten_d;
    logic             hold_q, hold_d;
    logic             thold_q, thold_d;
    logic             inc, dec, pin_sel, expire;

    always_comb begin
      pin_sel = (pin_step_ch_i == SEL_W'(g));
      inc     = (incdec_wr_i & incdec_i[INC_LSB + g]) | (pin_sel & pin_inc_p);
      dec     = (incdec_wr_i & incdec_i[DEC_LSB + g]) | (pin_sel & pin_dec_p);
      // whole word replaced in one cycle, so the divider never sees a half value
      fcw_d = fcw_q;
      if (fcw_wr_i[g]) begin
        fcw_d = fcw_wdata_i;
      end else if (inc && !dec) begin
        fcw_d = fcw_q + step_i[g];
      end else if (dec && !inc) begin
        fcw_d = fcw_q - step_i[g];
      end

      // phase-word timer, ms prescaled
      pcw_d   = pcw_q;
      tmr_d   = tmr_q;
      pre_d   = pre_q;
      thold_d = thold_q;
      expire  = 1'b0;
      if (pcw_wr_i[g]) begin
        pcw_d   = pcw_wdata_i;
        tmr_d   = tmr_ms_i;
        pre_d   = '0;
        thold_d = 1'b0;
      end else if (mode_i[g] != DCOST_WPHASE) begin
        thold_d = 1'b0;
      end else if (tmr_en_i[g] && tmr_q != '0) begin
        if (pre_q == PRE_LAST) begin
          pre_d = '0;
          tmr_d = tmr_q - 16'h0001;
          expire = (tmr_q == 16'h0001);
        end else begin
          pre_d = pre_q + 16'h0001;
        end
      end
      if (expire) begin
        if (tmr_hold_i[g]) begin
          thold_d = 1'b1;
        end else begin
          pcw_d = '0;
        end
      end

      // decimated phase error for the external filter
      dcnt_d = dcnt_q;
      prd_d  = prd_q;
      if (dcnt_q >= decim_i[g]) begin
        dcnt_d = '0;
        prd_d  = phase_err_i[g];
      end else begin
        dcnt_d = dcnt_q + 16'h0001;
      end

      // positive phase word acts as a positive error, so the loop speeds up
      ferr_d = (mode_i[g] == DCOST_WPHASE) ? pcw_q : phase_err_i[g];

      hold_d  = 1'b0;
      steer_d = steer_q;
      sten_d  = 1'b1;
      case (mode_i[g])
        DCOST_FREE: begin
          sten_d  = 1'b0;
          steer_d = FCW_RST;
        end
        DCOST_OSC: begin
          steer_d = sys_loop_i;
        end
        DCOST_JA: begin
          hold_d = refs_lost_i[g];
          if (!refs_lost_i[g]) begin
            steer_d = chan_loop_i[g];
          end
        end
        DCOST_EXTLF, DCOST_WFREQ: begin
          steer_d = fcw_q;
        end
        DCOST_WPHASE: begin
          hold_d = thold_q;
          if (!thold_q) begin
            steer_d = chan_loop_i[g];
          end
        end
        DCOST_REPL: begin
          // source frozen in holdover is followed as is
          steer_d = steer_all[repl_src_i[g]];
        end
        default: begin
          sten_d  = 1'b0;
          steer_d = FCW_RST;
        end
      endcase
    end

    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        fcw_q   <= FCW_RST;
        pcw_q   <= PCW_RST;
        tmr_q   <= TMR_RST;
        pre_q   <= '0;
        dcnt_q  <= '0;
        prd_q   <= PCW_RST;
        ferr_q  <= PCW_RST;
        steer_q <= FCW_RST;
        sten_q  <= 1'b0;
        hold_q  <= 1'b0;
        thold_q <= 1'b0;
      end else begin
        fcw_q   <= fcw_d;
        pcw_q   <= pcw_d;
        tmr_q   <= tmr_d;
        pre_q   <= pre_d;
        dcnt_q  <= dcnt_d;
        prd_q   <= prd_d;
        ferr_q  <= ferr_d;
        steer_q <= steer_d;
        sten_q  <= sten_d;
        hold_q  <= hold_d;
        thold_q <= thold_d;
      end
    end

    assign steer_all[g]    = steer_q;
    assign steer_o[g]      = steer_q;
    assign steer_en_o[g]   = sten_q;
    assign holdover_o[g]   = hold_q;
    assign filter_err_o[g] = ferr_q;
    assign phase_rd_o[g]   = prd_q;
    assign fcw_o[g]        = fcw_q;
  end : g_ch

endmodule : dcost_steering
`default_nettype wire

// file: include/dcost_pkg.sv
// Functional notes
// - free-run mode: divider not steered, fixed intermediate frequency 500 MHz to 1 GHz
// - oscillator-disciplined mode: system digital loop value steers the divider
// - jitter-attenuator mode: channel phase loop value steers the divider
// - a locked channel's steering value may be copied onto any other channel
// - all relevant inputs lost: channel enters holdover, steering frozen
// - external filter: measured phase error decimated to user rate, readable
// - external filter: written frequency word steers the divider directly
// - write-frequency mode: written frequency word bypasses detector and filter
// - new frequency word applied atomically; holds until the next write
// - word equals (1 - 1/(1+ppm/1e6)) * 2^53; positive raises frequency
// - frequency word covers +244.20 ppm to -244.08 ppm
// - coarse phase offset jumps at once; fine trim uses frequency writes
// - one 16-bit inc/dec write steps selected oscillators' cumulative words
// - each further inc/dec write applies another step, accumulating
// - configured pin steps one chosen oscillator, alternative to the register
// - write-phase mode: phase word feeds loop filter as measured phase error
// - phase-word timer expiry clears the word or enters holdover
// - timer is 16-bit unsigned in 1 ms units, max 65.535 s
// - phase word is 32-bit two's complement, 50 ps per bit
// - positive phase word speeds the output, negative slows it
package dcost_pkg;
  localparam int          NCH        = 8;
  localparam int          FCW_W      = 48;
  localparam int          FCW_SIG_W  = 42;
  localparam int          PCW_W      = 32;
  localparam int          TMR_W      = 16;
  localparam int          DEC_W      = 16;
  localparam int          SEL_W      = 3;
  localparam int          CLK_PS     = 25000;
  localparam int          MS_PS      = 1000000000;
  localparam int          MS_CYCLES  = MS_PS / CLK_PS;
  localparam int          PRE_W      = 16;
  localparam int          INC_LSB    = 0;
  localparam int          DEC_LSB    = 8;
  localparam logic [47:0] FCW_RST    = 48'h0000_0000_0000;
  localparam logic [31:0] PCW_RST    = 32'h0000_0000;
  localparam logic [15:0] TMR_RST    = 16'h0000;

  typedef enum logic [2:0] {
    DCOST_FREE   = 3'b000,
    DCOST_OSC    = 3'b001,
    DCOST_JA     = 3'b010,
    DCOST_EXTLF  = 3'b011,
    DCOST_WFREQ  = 3'b100,
    DCOST_WPHASE = 3'b101,
    DCOST_REPL   = 3'b110
  } dcost_mode_t;
endpackage : dcost_pkg

// file: tb/dcost_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcost_ctrl_model import dcost_pkg::*; (
  input  wire logic               clk_i,
  output var  logic [NCH-1:0]     fcw_wr_o,
  output var  logic [FCW_W-1:0]   fcw_wdata_o,
  output var  logic               incdec_wr_o,
  output var  logic [15:0]        incdec_o,
  output var  logic [NCH-1:0]     pcw_wr_o,
  output var  logic [PCW_W-1:0]   pcw_wdata_o,
  output var  logic [TMR_W-1:0]   tmr_ms_o
);
  initial begin
    {fcw_wr_o, fcw_wdata_o, incdec_wr_o, incdec_o, pcw_wr_o, pcw_wdata_o, tmr_ms_o} = '0;
  end
  // whole word in one strobe, never a partial update
  task automatic put_fcw(input int ch, input logic [41:0] w);
    @(posedge clk_i) #1 fcw_wdata_o = {{6{w[41]}}, w};
    fcw_wr_o[ch] = 1'b1;
    @(posedge clk_i) #1 fcw_wr_o = '0;
  endtask : put_fcw
  task automatic put_inc(input logic [15:0] v);
    @(posedge clk_i) #1 incdec_o = v;
    incdec_wr_o = 1'b1;
    @(posedge clk_i) #1 incdec_wr_o = 1'b0;
  endtask : put_inc
  task automatic put_pcw(input int ch, input logic [31:0] v, input logic [15:0] t);
    @(posedge clk_i) #1 pcw_wdata_o = v;
    tmr_ms_o = t;
    pcw_wr_o[ch] = 1'b1;
    @(posedge clk_i) #1 pcw_wr_o = '0;
  endtask : put_pcw
endmodule : dcost_ctrl_model
`default_nettype wire

// file: tb/dcost_steering_props.sv
`timescale 1ns/1ps
`default_nettype none
module dcost_steering_props import dcost_pkg::*; (
  input wire logic                      clk_i,
  input wire logic                      sys_rst_i,
  input wire dcost_mode_t [NCH-1:0]     mode_i,
  input wire logic [FCW_W-1:0]          sys_loop_i,
  input wire logic [NCH-1:0][FCW_W-1:0] chan_loop_i,
  input wire logic [NCH-1:0]            refs_lost_i,
  input wire logic [NCH-1:0]            fcw_wr_i,
  input wire logic [FCW_W-1:0]          fcw_wdata_i,
  input wire logic [NCH-1:0][FCW_W-1:0] step_i,
  input wire logic                      incdec_wr_i,
  input wire logic [15:0]               incdec_i,
  input wire logic                      pin_step_en_i,
  input wire logic [NCH-1:0][FCW_W-1:0] steer_o,
  input wire logic [NCH-1:0]            steer_en_o,
  input wire logic [NCH-1:0][FCW_W-1:0] fcw_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // pins off, so only the register path can step channel 0
  wire logic q0 = !fcw_wr_i[0] && !pin_step_en_i;
  a_fcw_load: assert property (fcw_wr_i[0] |=> fcw_o[0] == $past(fcw_wdata_i)) else $error("word not loaded");
  a_fcw_hold: assert property (q0 && !incdec_wr_i |=> $stable(fcw_o[0])) else $error("word moved");
  a_wfreq_pass: assert property (mode_i[0] == DCOST_WFREQ |=> steer_o[0] == $past(fcw_o[0]))
    else $error("steer not word");
  a_free_off: assert property (mode_i[0] == DCOST_FREE |=> !steer_en_o[0]) else $error("free steered");
  a_osc_steer: assert property (mode_i[0] == DCOST_OSC |=> steer_o[0] == $past(sys_loop_i))
    else $error("osc steer");
  a_ja_track: assert property (mode_i[0] == DCOST_JA && !refs_lost_i[0]
    |=> steer_o[0] == $past(chan_loop_i[0])) else $error("ja steer");
  a_ja_hold: assert property (mode_i[0] == DCOST_JA && refs_lost_i[0] |=> $stable(steer_o[0]))
    else $error("hold");
  a_inc_step: assert property (q0 && incdec_wr_i && incdec_i[0] && !incdec_i[8]
    |=> fcw_o[0] == $past(fcw_o[0]) + $past(step_i[0])) else $error("step");
  a_both_none: assert property (q0 && incdec_wr_i && incdec_i[0] && incdec_i[8] |=> $stable(fcw_o[0]))
    else $error("both stepped");
endmodule : dcost_steering_props
`default_nettype wire

// file: tb/dcost_steering_test.sv
`timescale 1ns/1ps
`default_nettype none
module dcost_steering_test;
  import dcost_pkg::*;
  logic                      clk_i = 0, sys_rst_i = 1, pin_step_en_i = 0, pin_inc_i = 0, pin_dec_i = 0;
  dcost_mode_t [NCH-1:0]     mode_i = '0;
  logic [NCH-1:0][SEL_W-1:0] repl_src_i = '0;
  logic [FCW_W-1:0]          sys_loop_i = '0;
  logic [NCH-1:0][FCW_W-1:0] chan_loop_i = '0, step_i = '0, steer_o, fcw_o;
  logic [NCH-1:0]            refs_lost_i = '0, tmr_en_i = '0, tmr_hold_i = '0, steer_en_o, holdover_o;
  logic [NCH-1:0][PCW_W-1:0] phase_err_i = '0, filter_err_o, phase_rd_o;
  logic [NCH-1:0][DEC_W-1:0] decim_i = '0;
  logic [SEL_W-1:0]          pin_step_ch_i = '0;
  wire logic [NCH-1:0]       fcw_wr_i, pcw_wr_i;
  wire logic [FCW_W-1:0]     fcw_wdata_i;
  wire logic                 incdec_wr_i;
  wire logic [15:0]          incdec_i;
  wire logic [PCW_W-1:0]     pcw_wdata_i;
  wire logic [TMR_W-1:0]     tmr_ms_i;
  int                        miscompares = 0, checked = 0;
  // short millisecond keeps timer runs to a few cycles
  dcost_steering #(.MS_CYC(4)) uut (.*);
  dcost_ctrl_model m (.clk_i, .fcw_wr_o(fcw_wr_i), .fcw_wdata_o(fcw_wdata_i), .incdec_wr_o(incdec_wr_i),
    .incdec_o(incdec_i), .pcw_wr_o(pcw_wr_i), .pcw_wdata_o(pcw_wdata_i), .tmr_ms_o(tmr_ms_i));
  always #12.5 clk_i = ~clk_i;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  initial begin
    cyc(5000);
    miscompares++;
    stop_test();
  end
  initial begin
    cyc(16);
    sys_rst_i = 0;
    chk(steer_en_o[0], 0);
    mode_i[0] = DCOST_WFREQ;
    decim_i[2] = 16'h0003;
    phase_err_i[2] = 32'h0000_00ab;
    m.put_fcw(0, 42'h3ff_ffff_fffb);
    cyc(1);
    chk(steer_o[0], 48'hffff_ffff_fffb);
    chk(steer_en_o[0], 1);
    step_i[0] = 48'h10;
    m.put_inc(16'h0001);
    m.put_inc(16'h0001);
    chk(fcw_o[0], 48'h1b);
    m.put_inc(16'h0101);
    chk(fcw_o[0], 48'h1b);
    m.put_inc(16'h0100);
    chk(fcw_o[0], 48'hb);
    mode_i[0] = DCOST_EXTLF;
    cyc(1);
    chk(steer_o[0], 48'hb);
    chk(phase_rd_o[2], 48'hab);
    chk(filter_err_o[2], 48'hab);
    // pins are asynchronous, so give the synchroniser a few cycles
    pin_step_en_i = 1;
    #50 pin_inc_i = 1;
    #100 pin_inc_i = 0;
    cyc(6);
    chk(fcw_o[0], 48'h1b);
    chk(steer_o[0], 48'h1b);
    #50 pin_dec_i = 1;
    #100 pin_dec_i = 0;
    cyc(6);
    chk(fcw_o[0], 48'hb);
    pin_step_en_i = 0;
    sys_loop_i = 48'h123;
    chan_loop_i[0] = 48'h456;
    mode_i[0] = DCOST_OSC;
    cyc(2);
    chk(steer_o[0], 48'h123);
    mode_i[0] = DCOST_JA;
    mode_i[1] = DCOST_REPL;
    cyc(3);
    chk(steer_o[0], 48'h456);
    chk(steer_o[1], 48'h456);
    refs_lost_i[0] = 1;
    chan_loop_i[0] = 48'h789;
    cyc(2);
    chk(steer_o[0], 48'h456);
    chk(holdover_o[0], 1);
    mode_i[0] = DCOST_FREE;
    refs_lost_i[0] = 0;
    cyc(2);
    chk(steer_en_o[0], 0);
    mode_i[0] = DCOST_WPHASE;
    tmr_en_i[0] = 1;
    m.put_pcw(0, 32'h64, 16'h2);
    cyc(5);
    chk(filter_err_o[0], 48'h64);
    cyc(6);
    chk(filter_err_o[0], 0);
    tmr_hold_i[0] = 1;
    m.put_pcw(0, 32'hffff_ff9c, 16'h1);
    cyc(8);
    chk(holdover_o[0], 1);
    stop_test();
  end
endmodule : dcost_steering_test
bind dcost_steering dcost_steering_props u_props (.*);
`default_nettype wire
